// File: hw/stm_pkg.sv
// constants and types shared by the bus timing monitor files
package stm_pkg;

    // ****************************************************************
    // time base
    // ****************************************************************
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;

    // ****************************************************************
    // bus time limits in microseconds, as specified
    // ****************************************************************
    localparam int unsigned CLOCK_LOW_TIMEOUT_US = 25_000; // lower end of 25..35 ms
    localparam int unsigned SLAVE_CUMULATIVE_STRETCH_LIMIT_US = 25_000;
    localparam int unsigned MASTER_BYTE_STRETCH_LIMIT_US = 10_000;
    localparam int unsigned CLOCK_HIGH_PERIOD_LIMIT_US = 50;

    // ****************************************************************
    // limits as clock cycles (exact at 125 MHz, no rounding needed)
    // ****************************************************************
    localparam int unsigned CLOCK_LOW_TIMEOUT_CYC = CLOCK_LOW_TIMEOUT_US * CLK_PER_US;
    localparam int unsigned SLAVE_STRETCH_CYC = SLAVE_CUMULATIVE_STRETCH_LIMIT_US * CLK_PER_US;
    localparam int unsigned MASTER_STRETCH_CYC = MASTER_BYTE_STRETCH_LIMIT_US * CLK_PER_US;
    localparam int unsigned CLOCK_HIGH_LIMIT_CYC = CLOCK_HIGH_PERIOD_LIMIT_US * CLK_PER_US;

    // ****************************************************************
    // interval timer layout
    // ****************************************************************
    localparam int unsigned TMR_N = 4;
    localparam int unsigned TMR_W = 22;
    localparam int unsigned TMR_LOW = 0;  // clock held low
    localparam int unsigned TMR_SLV = 1;  // own stretch, whole message
    localparam int unsigned TMR_MST = 2;  // master stretch, one byte
    localparam int unsigned TMR_IDLE = 3; // both lines high

    // ****************************************************************
    // byte framing and reset values
    // ****************************************************************
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h7; // lines idle high

    typedef enum logic [1:0]
    {
        STM_IDLE = 2'h0,
        STM_BUSY = 2'h1,
        STM_RECOVER = 2'h3
    } stm_state_t;

endpackage : stm_pkg

// File: hw/stm_tmr_if.sv
// control and status bundle between the monitor and its interval timers
`timescale 1ns/1ps
interface stm_tmr_if #(
    parameter int unsigned N = 4,
    parameter int unsigned W = 22
);
    logic [N-1:0] run;
    logic [N-1:0] clr;
    logic [N-1:0][W-1:0] limit;
    logic [N-1:0] over;

    modport ctrl
    (
        output run,
        output clr,
        output limit,
        input over
    );
    modport tmr
    (
        input run,
        input clr,
        input limit,
        output over
    );
endinterface : stm_tmr_if

// File: hw/stm_tmr.sv
// bank of saturating interval timers, one per supervised interval
`timescale 1ns/1ps
module stm_tmr #(
    parameter int unsigned N = 4,
    parameter int unsigned W = 22
)(
    input wire logic clk,
    input wire logic rst_n,
    stm_tmr_if.tmr t
);

    if (N < 1 || W < 2)
    begin : g_chk
        $error("stm_tmr: N must be at least 1 and W at least 2");
    end

    typedef struct packed
    {
        logic [N-1:0][W-1:0] cnt;
    } stm_tmr_state_t;

    stm_tmr_state_t s_q;
    stm_tmr_state_t s_d;

    // clear wins over run; counting stops at the limit so over stays a level
    always_comb
    begin
        s_d = s_q;
        for (int i = 0; i < N; i++)
        begin
            if (t.clr[i])
                s_d.cnt[i] = '0;
            else if (t.run[i] && s_q.cnt[i] != t.limit[i])
                s_d.cnt[i] = s_q.cnt[i] + W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // over comes straight from the count register
    for (genvar g = 0; g < N; g++)
    begin : g_over
        assign t.over[g] = (s_q.cnt[g] == t.limit[g]);
    end

endmodule : stm_tmr

// File: hw/stm_mon.sv
// two-wire bus timing and timeout supervisor for a slave device
// Summary of operation
// - clock held low past the 25..35 ms timeout is detected as a timeout.
// - on a timeout the interface resets and releases so the bus goes idle.
// - own clock stretching may total at most 25 ms per message.
// - exceeding that allowance releases both lines and resets the interface.
// - both lines high longer than 50 us means the bus is idle.
// - start conditions are recognised even at 100 kHz bus clock.
// - a clock stopped high while idle is normal, never an error; stopped low it still times out.
// - the device answers on a fixed slave address.
// - the slave answers within the transaction, in both read and write directions.
`timescale 1ns/1ps
module stm_mon #(
    parameter logic [6:0] SLAVE_ADDR = 7'h4a, // arbitrary fixed address
    parameter int unsigned CLOCK_LOW_TIMEOUT_CYC = stm_pkg::CLOCK_LOW_TIMEOUT_CYC,
    parameter int unsigned SLAVE_STRETCH_CYC = stm_pkg::SLAVE_STRETCH_CYC,
    parameter int unsigned MASTER_STRETCH_CYC = stm_pkg::MASTER_STRETCH_CYC,
    parameter int unsigned CLOCK_HIGH_LIMIT_CYC = stm_pkg::CLOCK_HIGH_LIMIT_CYC
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_clock_line,
    output logic bus_clock_line_out,
    output logic bus_clock_line_oe,
    input wire logic bus_data_line,
    output logic bus_data_line_out,
    output logic bus_data_line_oe,
    input wire logic hold_clock_req,
    input wire logic data_low_req,
    output logic bus_idle,
    output logic bus_busy,
    output logic start_pulse,
    output logic stop_pulse,
    output logic iface_reset,
    output logic clock_low_timeout,
    output logic slave_stretch_fault,
    output logic master_stretch_fault,
    output logic addr_hit,
    output logic addr_read
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    localparam int unsigned TMR_MAX = (1 << stm_pkg::TMR_W) - 1;

    if (CLOCK_LOW_TIMEOUT_CYC < 1 || CLOCK_LOW_TIMEOUT_CYC > TMR_MAX ||
        SLAVE_STRETCH_CYC < 1 || SLAVE_STRETCH_CYC > TMR_MAX ||
        MASTER_STRETCH_CYC < 1 || MASTER_STRETCH_CYC > TMR_MAX ||
        CLOCK_HIGH_LIMIT_CYC < 1 || CLOCK_HIGH_LIMIT_CYC > TMR_MAX)
    begin : g_chk
        $error("stm_mon: timer limits must lie in 1 .. 2**TMR_W-1");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed
    {
        logic [2:0] scl_sy;   // [0] first stage, [1] second, [2] previous
        logic [2:0] sda_sy;
        stm_pkg::stm_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic addr_phase;
        logic [stm_pkg::TMR_N-1:0] over_q;
        logic scl_oe;
        logic sda_oe;
        logic idle;
        logic start_p;
        logic stop_p;
        logic rst_p;
        logic low_p;
        logic sfault_p;
        logic mfault_p;
        logic hit_p;
        logic rw_read;
    } stm_mon_state_t;

    stm_mon_state_t s_q;
    stm_mon_state_t s_d;

    stm_tmr_if #(.N(stm_pkg::TMR_N), .W(stm_pkg::TMR_W)) tmr_bus ();

    logic scl;
    logic sda;
    logic scl_prev;
    logic sda_prev;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic ack_rise;
    logic [stm_pkg::TMR_N-1:0] over_rise;
    logic [7:0] byte_now;

    // ****************************************************************
    // line conditions, read only from the second sync stage onward
    // ****************************************************************
    assign scl = s_q.scl_sy[1];
    assign sda = s_q.sda_sy[1];
    assign scl_prev = s_q.scl_sy[2];
    assign sda_prev = s_q.sda_sy[2];
    // one-cycle sampling at 8 ns sees every edge even at 100 kHz
    assign start_det = scl && scl_prev && sda_prev && !sda;
    assign stop_det = scl && scl_prev && !sda_prev && sda;
    assign scl_rise = scl && !scl_prev;
    assign ack_rise = scl_rise && s_q.bit_cnt == stm_pkg::BIT_ACK;
    assign over_rise = tmr_bus.over & ~s_q.over_q;
    assign byte_now = {s_q.shift[6:0], sda};

    // ****************************************************************
    // interval timer control
    // ****************************************************************
    // low timer runs whenever the clock is low; a clock stopped high never counts
    assign tmr_bus.run[stm_pkg::TMR_LOW] = !scl;
    assign tmr_bus.clr[stm_pkg::TMR_LOW] = scl;
    // own stretch accumulates over the whole message, cleared only by a start
    assign tmr_bus.run[stm_pkg::TMR_SLV] = !scl && s_q.scl_oe;
    assign tmr_bus.clr[stm_pkg::TMR_SLV] = start_det;
    // clock low not caused by us is charged to the master, per byte
    assign tmr_bus.run[stm_pkg::TMR_MST] = !scl && !s_q.scl_oe &&
        s_q.st == stm_pkg::STM_BUSY;
    assign tmr_bus.clr[stm_pkg::TMR_MST] = start_det || stop_det || ack_rise;
    assign tmr_bus.run[stm_pkg::TMR_IDLE] = scl && sda;
    assign tmr_bus.clr[stm_pkg::TMR_IDLE] = !(scl && sda);
    assign tmr_bus.limit[stm_pkg::TMR_LOW] = stm_pkg::TMR_W'(CLOCK_LOW_TIMEOUT_CYC);
    assign tmr_bus.limit[stm_pkg::TMR_SLV] = stm_pkg::TMR_W'(SLAVE_STRETCH_CYC);
    assign tmr_bus.limit[stm_pkg::TMR_MST] = stm_pkg::TMR_W'(MASTER_STRETCH_CYC);
    assign tmr_bus.limit[stm_pkg::TMR_IDLE] = stm_pkg::TMR_W'(CLOCK_HIGH_LIMIT_CYC);

    stm_tmr #(
        .N(stm_pkg::TMR_N),
        .W(stm_pkg::TMR_W)
    ) stm_tmr_inst (
        .clk(clk),
        .rst_n(rst_n),
        .t(tmr_bus)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.scl_sy = {s_q.scl_sy[1], s_q.scl_sy[0], bus_clock_line};
        s_d.sda_sy = {s_q.sda_sy[1], s_q.sda_sy[0], bus_data_line};
        s_d.over_q = tmr_bus.over;
        s_d.idle = tmr_bus.over[stm_pkg::TMR_IDLE];
        s_d.start_p = start_det;
        s_d.stop_p = stop_det;
        s_d.rst_p = 1'b0;
        s_d.low_p = 1'b0;
        s_d.sfault_p = 1'b0;
        s_d.mfault_p = 1'b0;
        s_d.hit_p = 1'b0;

        // byte framing: eight data bits then the acknowledge bit
        if (start_det)
        begin
            s_d.bit_cnt = stm_pkg::BIT_CNT_RST;
            s_d.addr_phase = 1'b1;
        end
        else if (scl_rise)
        begin
            if (s_q.bit_cnt == stm_pkg::BIT_ACK)
            begin
                s_d.bit_cnt = stm_pkg::BIT_CNT_RST;
                s_d.addr_phase = 1'b0;
            end
            else
            begin
                s_d.shift = byte_now;
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end
        end

        case (s_q.st)
            stm_pkg::STM_IDLE:
            begin
                // a start seen while idle opens a message; a repeated start stays in the busy state
                if (start_det)
                    s_d.st = stm_pkg::STM_BUSY;
            end
            stm_pkg::STM_BUSY:
            begin
                // fixed address compared as the eighth bit is clocked in
                if (scl_rise && s_q.addr_phase &&
                    s_q.bit_cnt == stm_pkg::BIT_LAST_DATA &&
                    byte_now[7:1] == SLAVE_ADDR)
                begin
                    s_d.hit_p = 1'b1;
                    s_d.rw_read = byte_now[0];
                end
                if (over_rise[stm_pkg::TMR_MST])
                    s_d.mfault_p = 1'b1;
                if (over_rise[stm_pkg::TMR_SLV])
                begin
                    s_d.sfault_p = 1'b1;
                    s_d.rst_p = 1'b1;
                    s_d.st = stm_pkg::STM_RECOVER;
                end
                else if (over_rise[stm_pkg::TMR_LOW])
                begin
                    s_d.low_p = 1'b1;
                    s_d.rst_p = 1'b1;
                    s_d.st = stm_pkg::STM_RECOVER;
                end
                else if (stop_det)
                    s_d.st = stm_pkg::STM_IDLE;
            end
            stm_pkg::STM_RECOVER:
            begin
                // lines stay released until the bus is seen idle or restarted
                if (start_det)
                    s_d.st = stm_pkg::STM_BUSY;
                else if (stop_det || tmr_bus.over[stm_pkg::TMR_IDLE])
                    s_d.st = stm_pkg::STM_IDLE;
            end
            default:
                s_d.st = stm_pkg::STM_IDLE;
        endcase

        // a clock-low timeout in the idle state still resets the engine
        if (s_q.st == stm_pkg::STM_IDLE && over_rise[stm_pkg::TMR_LOW])
        begin
            s_d.low_p = 1'b1;
            s_d.rst_p = 1'b1;
        end

        // drive only inside a live message; recovery forces both released
        s_d.scl_oe = hold_clock_req && s_d.st == stm_pkg::STM_BUSY;
        s_d.sda_oe = data_low_req && s_d.st == stm_pkg::STM_BUSY;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.scl_sy <= stm_pkg::SYNC_RST;
            s_q.sda_sy <= stm_pkg::SYNC_RST;
            s_q.st <= stm_pkg::STM_IDLE;
            s_q.bit_cnt <= stm_pkg::BIT_CNT_RST;
            s_q.shift <= stm_pkg::SHIFT_RST;
        end
        else
            s_q <= s_d;
    end

    // ****************************************************************
    // outputs, all from the state register except the two constant-low line values
    // ****************************************************************
    assign bus_clock_line_out = 1'b0; // open drain: only ever pulls low
    assign bus_clock_line_oe = s_q.scl_oe;
    assign bus_data_line_out = 1'b0;
    assign bus_data_line_oe = s_q.sda_oe;
    assign bus_idle = s_q.idle;
    assign bus_busy = (s_q.st == stm_pkg::STM_BUSY);
    assign start_pulse = s_q.start_p;
    assign stop_pulse = s_q.stop_p;
    assign iface_reset = s_q.rst_p;
    assign clock_low_timeout = s_q.low_p;
    assign slave_stretch_fault = s_q.sfault_p;
    assign master_stretch_fault = s_q.mfault_p;
    assign addr_hit = s_q.hit_p;
    assign addr_read = s_q.rw_read;

endmodule : stm_mon

// File: dv/stm_mon_assertions.sv
// concurrent checks on the ports of the bus timing monitor
`timescale 1ns/1ps
module stm_mon_assertions #(
    parameter int unsigned CLOCK_LOW_TIMEOUT_CYC = 200,
    parameter int unsigned CLOCK_HIGH_LIMIT_CYC = 40
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_clock_line,
    input wire logic bus_clock_line_out,
    input wire logic bus_clock_line_oe,
    input wire logic bus_data_line,
    input wire logic bus_data_line_out,
    input wire logic bus_data_line_oe,
    input wire logic hold_clock_req,
    input wire logic data_low_req,
    input wire logic bus_idle,
    input wire logic bus_busy,
    input wire logic start_pulse,
    input wire logic stop_pulse,
    input wire logic iface_reset,
    input wire logic clock_low_timeout,
    input wire logic slave_stretch_fault,
    input wire logic master_stretch_fault,
    input wire logic addr_hit
);
    // ****************************************************************
    // raw pin interval counters
    // ****************************************************************
    localparam int TO = CLOCK_LOW_TIMEOUT_CYC;
    localparam int CH = CLOCK_HIGH_LIMIT_CYC;
    int lo_q;
    int hi_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // raw counts run ahead of the synchroniser, so bounds allow a few cycles of slack
    always_ff @(posedge clk)
    begin
        lo_q <= (!rst_n || bus_clock_line) ? 0 : lo_q + 1;
        hi_q <= (!rst_n || !(bus_clock_line && bus_data_line)) ? 0 : hi_q + 1;
    end
    chk_tmo_fires: assert property (lo_q == TO |-> ##[1:8] clock_low_timeout)
        else $error("clock low timeout missing");
    chk_tmo_cause: assert property (clock_low_timeout |-> lo_q >= TO && lo_q <= TO + 8)
        else $error("clock low timeout at wrong time");
    chk_tmo_release: assert property (clock_low_timeout |-> iface_reset && !bus_clock_line_oe
        && !bus_data_line_oe)
        else $error("timeout without release");
    chk_slv_release: assert property (slave_stretch_fault |-> iface_reset ##0
        (!bus_clock_line_oe && !bus_data_line_oe)[*2])
        else $error("stretch fault without release");
    chk_mst_only: assert property (master_stretch_fault && !clock_low_timeout
        && !slave_stretch_fault |-> !iface_reset)
        else $error("master fault reset the interface");
    chk_idle_rise: assert property ($rose(bus_idle) |-> hi_q >= CH)
        else $error("idle flagged too early");
    chk_idle_late: assert property (hi_q == CH + 10 |-> bus_idle)
        else $error("idle not flagged");
    chk_start_busy: assert property (start_pulse |-> bus_busy ##1 !start_pulse)
        else $error("start pulse malformed");
    chk_stop_free: assert property (stop_pulse |-> !bus_busy)
        else $error("busy after stop");
    chk_drive_req: assert property ((bus_clock_line_oe || bus_data_line_oe) |-> bus_busy
        && (!bus_clock_line_oe || $past(hold_clock_req))
        && (!bus_data_line_oe || $past(data_low_req)))
        else $error("pin driven without request");
    chk_open_drain: assert property (!bus_clock_line_out && !bus_data_line_out)
        else $error("open drain value high");
    chk_addr_busy: assert property (addr_hit |-> bus_busy)
        else $error("address hit outside a message");
    cov_start: cover property (start_pulse);
    cov_hit: cover property (addr_hit);
    cov_slv: cover property (slave_stretch_fault);
    cov_mst: cover property (master_stretch_fault);
endmodule : stm_mon_assertions
bind stm_mon stm_mon_assertions #(.CLOCK_LOW_TIMEOUT_CYC(CLOCK_LOW_TIMEOUT_CYC),
    .CLOCK_HIGH_LIMIT_CYC(CLOCK_HIGH_LIMIT_CYC)) stm_mon_assertions_inst (.clk, .rst_n,
    .bus_clock_line, .bus_clock_line_out, .bus_clock_line_oe, .bus_data_line,
    .bus_data_line_out, .bus_data_line_oe, .hold_clock_req, .data_low_req, .bus_idle,
    .bus_busy, .start_pulse, .stop_pulse, .iface_reset, .clock_low_timeout,
    .slave_stretch_fault, .master_stretch_fault, .addr_hit);

// File: dv/stm_master_model.sv
// behavioural bus master driving the clock and data lines
`timescale 1ns/1ps
module stm_master_model (
    input wire logic scl,
    output logic scl_low,
    output logic sda_low,
    output logic stall_err
);
    // ****************************************************************
    // line drive tasks
    // ****************************************************************
    // half of the 125 ns link period; bus limits in the bench are scaled down alike
    localparam realtime T = 62.5;
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        stall_err = 1'b0;
    end
    // release clock and wait out a slave stretch, bounded so a stuck line cannot hang
    task automatic rise;
        int n;
        scl_low = 1'b0;
        n = 0;
        while (scl !== 1'b1 && n < 4000)
        begin
            #1;
            n++;
        end
        if (n >= 4000)
            stall_err = 1'b1;
        #T;
    endtask : rise
    task automatic start_c;
        #4700;
        sda_low = 1'b1;
        #4000;
        scl_low = 1'b1;
    endtask : start_c
    // xt lengthens the low phase of the first two bits, a master stretch
    task automatic byte_out(input logic [7:0] b, input int xt);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low = (i > 0) ? !b[i-1] : 1'b0; // ninth bit released for the ack
            #(T + ((i > 6) ? xt : 0));
            rise;
            scl_low = 1'b1;
        end
    endtask : byte_out
    task automatic stop_c;
        sda_low = 1'b1;
        #T;
        scl_low = 1'b0;
        #4000;
        sda_low = 1'b0;
    endtask : stop_c
    task automatic hold(input int ns);
        #(ns);
    endtask : hold
endmodule : stm_master_model

// File: dv/stm_mon_tb_top.sv
// self-checking bench for the bus timing monitor
`timescale 1ns/1ps
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module stm_mon_tb_top;
    // ****************************************************************
    // environment
    // ****************************************************************
    localparam logic [6:0] SA = 7'h4a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hold_clock_req = 1'b0;
    logic data_low_req = 1'b0;
    logic m_scl_low, m_sda_low, stall_err, scl_w, sda_w;
    logic c_out, c_oe, d_out, d_oe, bus_idle, bus_busy, st_p, sp_p, irst, tmo, sf, mf;
    logic hit, addr_read;
    logic e_rd = 1'b0;
    int n_errors = 0;
    int checks = 0;
    int n_st = 0, n_sp = 0, n_hit = 0, n_tmo = 0, n_sf = 0, n_mf = 0, n_rst = 0;
    int e_st = 0, e_sp = 0, e_hit = 0, e_tmo = 0, e_sf = 0, e_mf = 0;
    always #4 clk = ~clk;
    // wired-and with pull-ups: a released line rises
    assign scl_w = !m_scl_low && (c_oe ? c_out : 1'b1);
    assign sda_w = !m_sda_low && (d_oe ? d_out : 1'b1);
    stm_mon #(.CLOCK_LOW_TIMEOUT_CYC(200), .SLAVE_STRETCH_CYC(150), .MASTER_STRETCH_CYC(100),
        .CLOCK_HIGH_LIMIT_CYC(40)) stm_mon_inst (.clk(clk), .rst_n(rst_n),
        .bus_clock_line(scl_w), .bus_clock_line_out(c_out), .bus_clock_line_oe(c_oe),
        .bus_data_line(sda_w), .bus_data_line_out(d_out), .bus_data_line_oe(d_oe),
        .hold_clock_req(hold_clock_req), .data_low_req(data_low_req), .bus_idle(bus_idle),
        .bus_busy(bus_busy), .start_pulse(st_p), .stop_pulse(sp_p), .iface_reset(irst),
        .clock_low_timeout(tmo), .slave_stretch_fault(sf), .master_stretch_fault(mf),
        .addr_hit(hit), .addr_read(addr_read));
    stm_master_model stm_master_model_inst (.scl(scl_w), .scl_low(m_scl_low),
        .sda_low(m_sda_low), .stall_err(stall_err));
    // event tally, sampled mid-cycle so a pulse is never read at the edge that launches it
    always @(negedge clk)
    begin
        if (st_p === 1'b1) n_st++;
        if (sp_p === 1'b1) n_sp++;
        if (hit === 1'b1) n_hit++;
        if (tmo === 1'b1) n_tmo++;
        if (sf === 1'b1) n_sf++;
        if (mf === 1'b1) n_mf++;
        if (irst === 1'b1) n_rst++;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task give_verdict;
        $display("n_errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task check_all;
        repeat (20) @(negedge clk);
        `CMP(n_st, e_st)
        `CMP(n_sp, e_sp)
        `CMP(n_hit, e_hit)
        `CMP(addr_read, e_rd)
        `CMP(n_tmo, e_tmo)
        `CMP(n_sf, e_sf)
        `CMP(n_mf, e_mf)
        `CMP(n_rst, e_tmo + e_sf)
        `CMP(bus_busy, 1'b0)
    endtask : check_all
    // address byte plus one random data byte; the model tracks the expected events
    task automatic msg(input bit is_hit, input logic rw, input int xt);
        logic [6:0] a;
        a = is_hit ? SA : 7'($urandom);
        if (!is_hit && a == SA)
            a = a ^ 7'h01;
        stm_master_model_inst.start_c();
        stm_master_model_inst.byte_out({a, rw}, xt);
        stm_master_model_inst.byte_out(8'($urandom), 0);
        stm_master_model_inst.stop_c();
        e_st++;
        e_sp++;
        e_mf += (xt > 0) ? 1 : 0;
        if (is_hit)
        begin
            e_hit++;
            e_rd = rw;
        end
        check_all;
    endtask : msg
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        give_verdict;
    end
    initial
    begin
        void'($urandom(32'h6e9608cd));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        data_low_req = 1'b1;
        repeat (60) @(negedge clk);
        `CMP(bus_idle, 1'b1)
        `CMP(d_oe, 1'b0)
        data_low_req = 1'b0;
        for (int i = 0; i < 6; i++)
            msg(i % 3 != 2, 1'($urandom), 0);
        msg(1'b1, 1'b1, 400);
        // clock held low inside a message: master fault first, then the timeout
        stm_master_model_inst.start_c();
        stm_master_model_inst.hold(2000);
        stm_master_model_inst.stop_c();
        e_st++;
        e_sp++;
        e_tmo++;
        e_mf++;
        check_all;
        // own stretch beyond the per-message allowance
        stm_master_model_inst.start_c();
        @(negedge clk);
        hold_clock_req = 1'b1;
        data_low_req = 1'b1; // all-zero byte, so our data pull never fights the master
        stm_master_model_inst.byte_out(8'h00, 0);
        @(negedge clk);
        `CMP(c_oe, 1'b0)
        `CMP(d_oe, 1'b0)
        hold_clock_req = 1'b0;
        data_low_req = 1'b0;
        stm_master_model_inst.stop_c();
        e_st++;
        e_sp++;
        e_sf++;
        check_all;
        msg(1'b1, 1'b0, 0);
        `CMP(stall_err, 1'b0)
        give_verdict;
    end
endmodule : stm_mon_tb_top
